// file: sim/afd_field_model.sv
`timescale 1ns/1ps
module afd_field_model
  import afd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [36:0] cmd,
  output      afd_field_s  field_in,
  output      logic [9:0]  phase_current,
  output      logic [9:0]  resid_current
);
  // sensors and current measurement move only just after a clock edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {phase_current, resid_current, field_in} <= '0;
    end else begin
      {phase_current, resid_current, field_in} <= cmd;
    end
  end
endmodule // afd_field_model

// file: sim/tb_arc_flash_stage_matrix.sv
`timescale 1ns/1ps
module tb_arc_flash_stage_matrix
  import afd_pkg::*;
;
  logic        sys_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, hw = 1;
  logic [7:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd;
  logic        avs_waitrequest, alarm_output, install_ready;
  logic [3:0]  trip_outputs;
  logic [1:0]  fast_semiconductor_outputs;
  logic [EVT_W-1:0] evt_on, evt_off;
  logic [36:0] stim = '0;
  afd_field_s  field_in;
  logic [9:0]  ph, re;
  int          failures = 0, checks_done = 0, cyc = 0, ev_on_n = 0, ev_off_n = 0, n;
  logic [39:0] cfg [15] = '{40'h00_0000000F, 40'h40_00000001, 40'h24_00000001,
    40'h48_00000002, 40'h28_00000002, 40'h4C_00000400, 40'h2C_00000008,
    40'h50_00000004, 40'h80_00000001, 40'h84_00000002, 40'h88_00000004,
    40'h8C_00000008, 40'h90_00000010, 40'h94_00000005, 40'h98_00000002};
  // rows: {phase, resid, field} -> {alarm, fast, trip}
  logic [43:0] rows [10] = '{{37'h0, 7'h00}, {37'h0_00001, 7'h11},
    {10'h064, 10'h0, 17'h0, 7'h22}, {10'h063, 10'h0, 17'h0, 7'h00},
    {20'h0, 17'h00002, 7'h00}, {10'h0, 10'h064, 17'h0, 7'h00},
    {10'h0, 10'h064, 17'h00002, 7'h14}, {20'h0, 17'h00C00, 7'h08},
    {20'h0, 17'h00400, 7'h00}, {20'h0, 17'h00004, 7'h00}};

  afd_field_model i_afd_field_model (.sys_clk(sys_clk), .arst_n(arst_n), .cmd(stim),
    .field_in(field_in), .phase_current(ph), .resid_current(re));
  afd_stage_matrix #(.TICK_CYC(20), .INSTALL_CYC(4)) i_afd_stage_matrix (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .phase_current(ph), .resid_current(re),
    .field_in(field_in), .arc_hw_present(hw), .trip_outputs(trip_outputs),
    .alarm_output(alarm_output), .fast_semiconductor_outputs(fast_semiconductor_outputs),
    .evt_on(evt_on), .evt_off(evt_off), .install_ready(install_ready));

  always #2.5 sys_clk = ~sys_clk;

  always @(negedge sys_clk) begin
    if (evt_on[2] === 1'b1) ev_on_n++;
    if (evt_off[2] === 1'b1) ev_off_n++;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one Avalon transfer; waitrequest and readdata taken at the rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, '0);
    chk(rd, exp);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic tally_and_finish();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic time_trip();
    @(posedge sys_clk);
    stim <= 37'h1;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (trip_outputs[0] !== 1'b1 && n < 200);
    chk({31'h0, n >= 61 && n <= 84}, 32'h1);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_chk(OFF_STG_EN, 32'h0);
    rd_chk(OFF_PH_THR, 32'h64);
    rd_chk(OFF_RE_THR, 32'h64);
    rd_chk(OFF_EVT_EN, 32'h3FFFFF);
    bus(1'b1, 8'h9C, 32'hFF);
    rd_chk(8'h9C, 32'h0);
    // operator waits for ready before configuring
    bus(1'b1, OFF_INSTALL, 32'h1);
    @(negedge sys_clk);
    chk({31'h0, install_ready}, 32'h0);
    n = 0;
    while (install_ready !== 1'b1 && n < 50) begin
      settle(1);
      n++;
    end
    chk({31'h0, install_ready}, 32'h1);
    foreach (cfg[i]) bus(1'b1, cfg[i][39:32], cfg[i][31:0]);
    rd_chk(OFF_STATUS, 32'h300);
    bus(1'b0, OFF_GEN_RT, '0);
    chk(rd & 32'h7F, 32'h7F);
    foreach (rows[i]) begin
      @(posedge sys_clk);
      stim <= rows[i][43:7];
      settle(5);
      chk({alarm_output, fast_semiconductor_outputs, trip_outputs}, rows[i][6:0]);
    end
    chk(ev_on_n, 1);
    chk(ev_off_n, 1);
    // enabled stage 5 drives the alarm output from light sensor 3
    bus(1'b1, OFF_STG_EN, 32'h1F);
    stim <= 37'h4;
    settle(5);
    chk({31'h0, alarm_output}, 32'h1);
    @(posedge sys_clk);
    stim <= '0;
    settle(5);
    chk({31'h0, alarm_output}, 32'h0);
    // latched fast output, with light sensor 1 events masked
    bus(1'b1, 8'h94, 32'h101);
    bus(1'b1, OFF_EVT_EN, 32'h3FFFFB);
    stim <= 37'h1;
    settle(5);
    @(posedge sys_clk);
    stim <= '0;
    settle(5);
    chk({trip_outputs, fast_semiconductor_outputs}, 6'h01);
    bus(1'b1, OFF_OUT_CLR, 32'h20);
    settle(3);
    chk(fast_semiconductor_outputs, 2'h0);
    chk(ev_on_n + ev_off_n, 2);
    bus(1'b1, OFF_PH_THR, 32'h10);
    rd_chk(OFF_PH_THR, 32'h32);
    bus(1'b1, OFF_RE_THR, 32'h3FF);
    rd_chk(OFF_RE_THR, 32'h1F4);
    hw <= 1'b0;
    bus(1'b1, OFF_PH_THR, 32'h200);
    rd_chk(OFF_PH_THR, 32'h32);
    // delay set on stage 1 only; a 2 ms light pulse must not trip
    bus(1'b1, 8'h60, 32'h3);
    @(posedge sys_clk);
    stim <= 37'h1;
    settle(40);
    @(posedge sys_clk);
    stim <= '0;
    settle(3);
    chk(trip_outputs, 4'h0);
    time_trip();
    @(posedge sys_clk);
    stim <= '0;
    settle(5);
    time_trip();
    tally_and_finish();
  end
endmodule // tb_arc_flash_stage_matrix

// file: src/afd_pkg.sv
// Contract
// - eight stages; current selection from overcurrent flags, network, virtual outputs, stages
// - light selection per stage from ten sensors, network input, virtual outputs
// - stage using both selections active only when light and current selections both hit
// - stage with only one selection used runs from that selection alone
// - each trip and alarm output driven by its routed stages
// - per-output latch enable holds output after driving stage drops
// - routed connections also shown in general routing status
// - routing offers only fast directly driven outputs as destinations
// - events per source, gated by source enable and on/off enables, default on
// - phase threshold 0.50 to 8.00 times nominal in 0.01 steps
// - residual threshold 0.10 to 5.00 times nominal in 0.01 steps
// - fast outputs driven within 2 ms of undelayed stage condition
// - delayed operation never shorter than set delay, at most 10 ms longer
// - thresholds cannot be set without arc protection hardware present
// - install command shows installing state, then ready; operator waits
// - disabled stage never becomes active
// - per-stage trip delay 0 to 255 ms
package afd_pkg;
  localparam int NUM_STG  = 8;
  localparam int NUM_LGT  = 10;
  localparam int NUM_VIRT = 6;
  localparam int NUM_OUT  = 7;
  localparam int CUR_W    = 17;
  localparam int LGT_W    = 25;
  localparam int EVT_W    = 20;
  localparam int CLK_HZ        = 200000000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYC_DEF  = CLK_HZ / 1000 * TICK_MS;
  localparam int INSTALL_CYC_DEF = 64;
  localparam logic [9:0] PH_THR_MIN = 10'h032;
  localparam logic [9:0] PH_THR_MAX = 10'h320;
  localparam logic [9:0] RE_THR_MIN = 10'h00A;
  localparam logic [9:0] RE_THR_MAX = 10'h1F4;
  localparam logic [9:0] THR_RST    = 10'h064;
  localparam logic [21:0] EVT_EN_RST = 22'h3FFFFF;
  localparam logic [7:0] OFF_STG_EN  = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_INSTALL = 8'h08;
  localparam logic [7:0] OFF_PH_THR  = 8'h0C;
  localparam logic [7:0] OFF_RE_THR  = 8'h10;
  localparam logic [7:0] OFF_EVT_EN  = 8'h14;
  localparam logic [7:0] OFF_OUT_CLR = 8'h18;
  localparam logic [7:0] OFF_GEN_RT  = 8'h1C;
  localparam logic [2:0] BLK_CUR  = 3'h1;
  localparam logic [2:0] BLK_LGT  = 3'h2;
  localparam logic [2:0] BLK_DLY  = 3'h3;
  localparam logic [2:0] BLK_ROUTE = 3'h4;
  typedef struct packed {
    logic [NUM_VIRT-1:0] virt;
    logic                net;
    logic [NUM_LGT-1:0]  light;
  } afd_field_s;
  typedef struct packed {
    logic               latch;
    logic [NUM_STG-1:0] stages;
  } afd_route_s;
  typedef enum logic {INST_READY = 1'b0, INST_BUSY = 1'b1} afd_inst_e;
endpackage

// file: src/afd_stage_matrix.sv
`timescale 1ns/1ps
module afd_stage_matrix
  import afd_pkg::*;
#(
  parameter int TICK_CYC    = TICK_CYC_DEF,
  parameter int INSTALL_CYC = INSTALL_CYC_DEF
) (
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output      logic [31:0]        avs_readdata,
  output      logic               avs_waitrequest,
  input  wire logic [9:0]         phase_current,
  input  wire logic [9:0]         resid_current,
  input  wire afd_field_s         field_in,
  input  wire logic               arc_hw_present,
  output      logic [3:0]         trip_outputs,
  output      logic               alarm_output,
  output      logic [1:0]         fast_semiconductor_outputs,
  output      logic [EVT_W-1:0]   evt_on,
  output      logic [EVT_W-1:0]   evt_off,
  output      logic               install_ready
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int IW = $clog2(INSTALL_CYC + 1);

  function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo,
                                       input logic [9:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  function automatic logic stage_cond(input logic en, input logic [CUR_W-1:0] cs,
                                      input logic [CUR_W-1:0] cv,
                                      input logic [LGT_W-1:0] ls,
                                      input logic [LGT_W-1:0] lv);
    logic c_hit;
    logic l_hit;
    c_hit = |(cs & cv);
    l_hit = |(ls & lv);
    if (!en) return 1'b0;
    if ((cs != '0) && (ls != '0)) return c_hit & l_hit;
    if (cs != '0) return c_hit;
    if (ls != '0) return l_hit;
    return 1'b0;
  endfunction

  logic               ack_r;
  logic [31:0]        rd_r;
  logic [31:0]        rd_nxt;
  logic               wr_go;
  logic [2:0]         blk;
  logic [2:0]         idx;
  logic [NUM_STG-1:0] stage_en_r;
  logic [CUR_W-1:0]   cur_sel_r [NUM_STG];
  logic [LGT_W-1:0]   lgt_sel_r [NUM_STG];
  logic [7:0]         delay_r [NUM_STG];
  afd_route_s         route_r [NUM_OUT];
  logic [9:0]         ph_thr_r;
  logic [9:0]         re_thr_r;
  logic [21:0]        evt_en_r;
  logic [NUM_OUT-1:0] clr_pulse;
  afd_inst_e          inst_r;
  logic [IW-1:0]      inst_cnt_r;
  logic [TW-1:0]      tick_cnt_r;
  logic               tick;
  logic               phase_oc;
  logic               resid_oc;
  logic [CUR_W-1:0]   cur_vec;
  logic [LGT_W-1:0]   lgt_vec;
  logic [NUM_STG-1:0] cond;
  logic [NUM_STG-1:0] stage_active_r;
  logic [8:0]         ms_cnt_r [NUM_STG];
  logic [NUM_OUT-1:0] drive;
  logic [NUM_OUT-1:0] connected;
  logic [NUM_OUT-1:0] held_r;
  logic [NUM_OUT-1:0] held_nxt;
  logic [NUM_OUT-1:0] out_r;
  logic [EVT_W-1:0]   src;
  logic [EVT_W-1:0]   src_prev_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // bus slave: one wait cycle per access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rd_r;
  assign wr_go           = avs_write & ack_r;
  assign blk             = avs_address[7:5];
  assign idx             = avs_address[4:2];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      rd_r  <= '0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (avs_read && !ack_r) begin
        rd_r <= rd_nxt;
      end
    end
  end

  always_comb begin
    rd_nxt = '0;
    case (avs_address)
      OFF_STG_EN: rd_nxt = 32'(stage_en_r);
      OFF_STATUS: rd_nxt = {22'h000000, arc_hw_present, install_ready, stage_active_r};
      OFF_PH_THR: rd_nxt = 32'(ph_thr_r);
      OFF_RE_THR: rd_nxt = 32'(re_thr_r);
      OFF_EVT_EN: rd_nxt = 32'(evt_en_r);
      OFF_GEN_RT: rd_nxt = {17'h00000, out_r, 1'b0, connected};
      default: begin
        case (blk)
          BLK_CUR: rd_nxt = 32'(cur_sel_r[idx]);
          BLK_LGT: rd_nxt = 32'(lgt_sel_r[idx]);
          BLK_DLY: rd_nxt = 32'(delay_r[idx]);
          BLK_ROUTE: rd_nxt = (idx < 3'(NUM_OUT)) ? 32'(route_r[idx]) : 32'h00000000;
          default: rd_nxt = 32'h00000000;
        endcase
      end
    endcase
  end

  // configuration writes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_en_r <= '0;
      ph_thr_r   <= THR_RST;
      re_thr_r   <= THR_RST;
      evt_en_r   <= EVT_EN_RST;
      for (int i = 0; i < NUM_STG; i++) begin
        cur_sel_r[i] <= '0;
        lgt_sel_r[i] <= '0;
        delay_r[i]   <= '0;
      end
      for (int i = 0; i < NUM_OUT; i++) begin
        route_r[i] <= '0;
      end
    end else if (wr_go) begin
      case (avs_address)
        OFF_STG_EN: stage_en_r <= avs_writedata[7:0];
        OFF_PH_THR: begin
          if (arc_hw_present) begin
            ph_thr_r <= clamp(avs_writedata[9:0], PH_THR_MIN, PH_THR_MAX);
          end
        end
        OFF_RE_THR: begin
          if (arc_hw_present) begin
            re_thr_r <= clamp(avs_writedata[9:0], RE_THR_MIN, RE_THR_MAX);
          end
        end
        OFF_EVT_EN: evt_en_r <= avs_writedata[21:0];
        default: begin
          case (blk)
            BLK_CUR: cur_sel_r[idx] <= avs_writedata[CUR_W-1:0];
            BLK_LGT: lgt_sel_r[idx] <= avs_writedata[LGT_W-1:0];
            BLK_DLY: delay_r[idx] <= avs_writedata[7:0];
            BLK_ROUTE: begin
              if (idx < 3'(NUM_OUT)) begin
                route_r[idx] <= avs_writedata[8:0];
              end
            end
            default: ;
          endcase
        end
      endcase
    end
  end

  assign clr_pulse = (wr_go && avs_address == OFF_OUT_CLR) ? avs_writedata[NUM_OUT-1:0]
                                                           : '0;

  // sensor installation sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      inst_r     <= INST_READY;
      inst_cnt_r <= '0;
    end else if (wr_go && avs_address == OFF_INSTALL && avs_writedata[0]) begin
      inst_r     <= INST_BUSY;
      inst_cnt_r <= '0;
    end else if (inst_r == INST_BUSY) begin
      inst_cnt_r <= inst_cnt_r + IW'(1);
      if (inst_cnt_r == IW'(INSTALL_CYC - 1)) begin
        inst_r <= INST_READY;
      end
    end
  end
  assign install_ready = (inst_r == INST_READY);

  // millisecond tick
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end
  assign tick = (tick_cnt_r == TW'(TICK_CYC - 1));

  assign phase_oc = phase_current >= ph_thr_r;
  assign resid_oc = resid_current >= re_thr_r;
  assign cur_vec  = {stage_active_r, field_in.virt, field_in.net, resid_oc, phase_oc};
  assign lgt_vec  = {stage_active_r, field_in.virt, field_in.net, field_in.light};

  genvar s;
  generate
    for (s = 0; s < NUM_STG; s++) begin : g_stage
      logic [31:0] cyc_r;
      assign cond[s] = stage_cond(stage_en_r[s], cur_sel_r[s], cur_vec,
                                  lgt_sel_r[s], lgt_vec);
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          ms_cnt_r[s] <= '0;
        end else if (!cond[s]) begin
          ms_cnt_r[s] <= '0;
        end else if (tick && ms_cnt_r[s] <= {1'b0, delay_r[s]}) begin
          ms_cnt_r[s] <= ms_cnt_r[s] + 9'h001;
        end
      end
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          stage_active_r[s] <= 1'b0;
        end else begin
          stage_active_r[s] <= cond[s] &&
            (delay_r[s] == 8'h00 || ms_cnt_r[s] > {1'b0, delay_r[s]});
        end
      end
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          cyc_r <= '0;
        end else begin
          cyc_r <= cond[s] ? cyc_r + 32'h00000001 : 32'h00000000;
        end
      end
      chk_stage_disabled: assert property (!stage_en_r[s] |=> !stage_active_r[s])
        else $error("disabled stage went active");
      chk_and_combine: assert property ((cur_sel_r[s] != '0) && (lgt_sel_r[s] != '0) &&
        !(|(lgt_sel_r[s] & lgt_vec)) |=> !stage_active_r[s])
        else $error("stage active without light hit");
      chk_light_only: assert property (stage_en_r[s] && cur_sel_r[s] == '0 &&
        delay_r[s] == 8'h00 && (|(lgt_sel_r[s] & lgt_vec)) |=> stage_active_r[s])
        else $error("light-only stage failed to act");
      chk_delay_floor: assert property ($rose(stage_active_r[s]) && delay_r[s] != 8'h00
        |-> $past(cyc_r) >= 32'(delay_r[s]) * 32'(TICK_CYC))
        else $error("stage acted before its delay");
      chk_delay_restart: assert property (!cond[s] |=> ms_cnt_r[s] == 9'h000)
        else $error("delay count did not restart");
    end
  endgenerate

  genvar o;
  generate
    for (o = 0; o < NUM_OUT; o++) begin : g_out
      assign drive[o]     = |(route_r[o].stages & stage_active_r);
      assign connected[o] = |route_r[o].stages;
      assign held_nxt[o]  = route_r[o].latch & (drive[o] | (held_r[o] & ~clr_pulse[o]));
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          held_r[o] <= 1'b0;
          out_r[o]  <= 1'b0;
        end else begin
          held_r[o] <= held_nxt[o];
          out_r[o]  <= drive[o] | held_nxt[o];
        end
      end
      chk_route_drive: assert property (drive[o] |=> out_r[o])
        else $error("routed stage did not drive output");
      chk_latch_hold: assert property (route_r[o].latch && out_r[o] && !clr_pulse[o]
        |=> out_r[o])
        else $error("latched output dropped");
      chk_clear_release: assert property (clr_pulse[o] && !drive[o] |=> !out_r[o])
        else $error("output held after clear");
    end
  endgenerate

  assign trip_outputs               = out_r[3:0];
  assign alarm_output               = out_r[4];
  assign fast_semiconductor_outputs = out_r[6:5];

  // activation and deactivation events
  assign src = {stage_active_r, field_in.light, resid_oc, phase_oc};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_prev_r <= '0;
      evt_on     <= '0;
      evt_off    <= '0;
    end else begin
      src_prev_r <= src;
      evt_on     <= src & ~src_prev_r & evt_en_r[EVT_W-1:0] & {EVT_W{evt_en_r[20]}};
      evt_off    <= ~src & src_prev_r & evt_en_r[EVT_W-1:0] & {EVT_W{evt_en_r[21]}};
    end
  end

  sequence s_install_cmd;
    wr_go && avs_address == OFF_INSTALL && avs_writedata[0];
  endsequence

  chk_install_busy: assert property (s_install_cmd |=> !install_ready [*2])
    else $error("install did not report installing");
  chk_event_gate: assert property ((evt_on | evt_off) != '0 |-> $past(evt_en_r[19:0]) != '0)
    else $error("event raised with all sources disabled");
  chk_thr_locked: assert property (!arc_hw_present |=> $stable(ph_thr_r)
    && $stable(re_thr_r))
    else $error("threshold changed without hardware");
  chk_thr_range: assert property (ph_thr_r >= PH_THR_MIN && ph_thr_r <= PH_THR_MAX &&
    re_thr_r >= RE_THR_MIN && re_thr_r <= RE_THR_MAX)
    else $error("threshold out of range");
endmodule // afd_stage_matrix
